// ### hw/tcit_counter.sv
// module: one 16-bit presettable down-counter with four modes
`timescale 1ns/1ps
`default_nettype none
module tcit_counter
    import tcit_pkg::*;
#(
    parameter int CNT_W = TCIT_CNT_W
)(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    // host load
    input wire tcit_load_t i_load,
    // pins
    input wire tcit_pins_t i_pins,
    // output
    output logic o_out,
    output logic [CNT_W-1:0] o_count
);
    typedef enum logic [1:0] {
        TCIT_ST_IDLE = 2'b00,
        TCIT_ST_ARMED = 2'b01,
        TCIT_ST_RUN = 2'b11,
        TCIT_ST_DONE = 2'b10
    } tcit_st_t;

    tcit_st_t st_r, st_nxt;
    tcit_mode_t mode_r, mode_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt, init_r, init_nxt;
    logic out_r, out_nxt, clk_d_r, gate_d_r, clk_d_nxt, gate_d_nxt;
    logic tick, trig;
    logic pend_r, pend_nxt;

    // edges of the clock and gate pins
    assign tick = i_pins.clk_in & ~clk_d_r;
    assign trig = i_pins.gate & ~gate_d_r;

    always_comb
    begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        cnt_nxt = cnt_r;
        init_nxt = init_r;
        out_nxt = out_r;
        clk_d_nxt = i_pins.clk_in;
        gate_d_nxt = i_pins.gate;
        pend_nxt = pend_r;
        if (i_load.load)
        begin
            mode_nxt = tcit_decode_mode(i_load.mode_select_field);
            pend_nxt = 1'b0;
            init_nxt = i_load.count;
            if (tcit_decode_mode(i_load.mode_select_field) == TCIT_MODE_TC)
            begin
                out_nxt = 1'b0;
                cnt_nxt = i_load.count;
                st_nxt = TCIT_ST_ARMED;
            end
            else if (st_r != TCIT_ST_RUN || mode_r != tcit_decode_mode(i_load.mode_select_field)
                || mode_r == TCIT_MODE_ONESHOT)
            begin
                out_nxt = 1'b1;
                st_nxt = TCIT_ST_ARMED;
            end
            // running rate or square keeps its cycle until the next reload
        end
        else
        begin
            case (mode_r)
                TCIT_MODE_TC:
                begin
                    if (st_r == TCIT_ST_ARMED && trig)
                        st_nxt = TCIT_ST_RUN;
                    else if (st_r == TCIT_ST_RUN && tick && i_pins.gate)
                    begin
                        cnt_nxt = cnt_r - 1'b1;
                        if (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1})
                        begin
                            out_nxt = 1'b1;
                            st_nxt = TCIT_ST_DONE;
                        end
                    end
                end
                TCIT_MODE_ONESHOT:
                begin
                    if (trig && st_r != TCIT_ST_IDLE)
                    begin
                        // count taken on the next clock pulse
                        pend_nxt = 1'b1;
                        st_nxt = TCIT_ST_RUN;
                    end
                    else if (st_r == TCIT_ST_RUN && tick)
                    begin
                        out_nxt = 1'b0;
                        if (pend_r)
                        begin
                            pend_nxt = 1'b0;
                            cnt_nxt = init_r;
                        end
                        else
                        begin
                            cnt_nxt = cnt_r - 1'b1;
                            if (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1})
                            begin
                                out_nxt = 1'b1;
                                st_nxt = TCIT_ST_DONE;
                            end
                        end
                    end
                end
                TCIT_MODE_RATE:
                begin
                    if (!i_pins.gate)
                    begin
                        out_nxt = 1'b1;
                        if (st_r == TCIT_ST_RUN)
                            st_nxt = TCIT_ST_ARMED;
                    end
                    else if (trig && st_r == TCIT_ST_ARMED)
                    begin
                        cnt_nxt = init_r;
                        st_nxt = TCIT_ST_RUN;
                    end
                    else if (st_r == TCIT_ST_RUN && tick)
                    begin
                        if (cnt_r == {{(CNT_W-2){1'b0}}, 2'b10})
                        begin
                            out_nxt = 1'b0;
                            cnt_nxt = cnt_r - 1'b1;
                        end
                        else if (cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1})
                        begin
                            out_nxt = 1'b1;
                            cnt_nxt = init_r;
                        end
                        else
                        begin
                            out_nxt = 1'b1;
                            cnt_nxt = cnt_r - 1'b1;
                        end
                    end
                end
                default:
                begin
                    if (!i_pins.gate)
                    begin
                        out_nxt = 1'b1;
                        if (st_r == TCIT_ST_RUN)
                            st_nxt = TCIT_ST_ARMED;
                    end
                    else if (trig && st_r == TCIT_ST_ARMED)
                    begin
                        out_nxt = 1'b1;
                        cnt_nxt = {init_r[CNT_W-1:1], 1'b0};
                        if (init_r[0])
                            cnt_nxt = {init_r[CNT_W-1:1], 1'b0} + 2'd2;
                        st_nxt = TCIT_ST_RUN;
                    end
                    else if (st_r == TCIT_ST_RUN && tick)
                    begin
                        if (cnt_r <= {{(CNT_W-2){1'b0}}, 2'b10})
                        begin
                            out_nxt = ~out_r;
                            // odd count: high half one longer, low half one shorter
                            cnt_nxt = {init_r[CNT_W-1:1], 1'b0};
                            if (init_r[0] && !out_r)
                                cnt_nxt = {init_r[CNT_W-1:1], 1'b0} + 2'd2;
                        end
                        else
                        begin
                            cnt_nxt = cnt_r - 2'd2;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            st_r <= TCIT_ST_IDLE;
            mode_r <= TCIT_MODE_TC;
            cnt_r <= CNT_W'(TCIT_RST_COUNT);
            init_r <= CNT_W'(TCIT_RST_COUNT);
            out_r <= 1'b1;
            // idle level of the pulled-up pin, no false edge after reset
            clk_d_r <= 1'b1;
            gate_d_r <= 1'b1;
            pend_r <= 1'b0;
        end
        else if (i_ce)
        begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            cnt_r <= cnt_nxt;
            init_r <= init_nxt;
            out_r <= out_nxt;
            clk_d_r <= clk_d_nxt;
            gate_d_r <= gate_d_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign o_out = out_r;
    assign o_count = cnt_r;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_tc_load_low;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && i_load.load && i_load.mode_select_field[1:0] == 2'b00) |=> !o_out;
    endproperty
    a_tc_load_low: assert property (p_tc_load_low) else $error("load did not drive low");

    property p_tc_hold;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && mode_r == TCIT_MODE_TC && !i_load.load && !i_pins.gate) |=> $stable(cnt_r);
    endproperty
    a_tc_hold: assert property (p_tc_hold) else $error("count moved with gate low");

    property p_armed_wait;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && st_r == TCIT_ST_ARMED && mode_r == TCIT_MODE_TC && !trig && !i_load.load)
        |=> st_r == TCIT_ST_ARMED;
    endproperty
    a_armed_wait: assert property (p_armed_wait) else $error("ran without trigger");

    property p_os_reload;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && mode_r == TCIT_MODE_ONESHOT && st_r == TCIT_ST_RUN && pend_r && tick && !trig
            && !i_load.load) |=> (cnt_r == init_r && !o_out);
    endproperty
    a_os_reload: assert property (p_os_reload) else $error("retrigger missed");

    property p_rate_gate;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && mode_r == TCIT_MODE_RATE && !i_pins.gate && !i_load.load) |=> o_out;
    endproperty
    a_rate_gate: assert property (p_rate_gate) else $error("rate ran gate low");

    property p_rate_low_one;
        @(posedge i_clock) disable iff (i_rst)
        (mode_r == TCIT_MODE_RATE && $fell(o_out)) |-> cnt_r == {{(CNT_W-1){1'b0}}, 1'b1};
    endproperty
    a_rate_low_one: assert property (p_rate_low_one) else $error("rate low at bad count");

    property p_sq_even;
        @(posedge i_clock) disable iff (i_rst)
        (mode_r == TCIT_MODE_SQUARE && st_r == TCIT_ST_RUN) |-> !cnt_r[0];
    endproperty
    a_sq_even: assert property (p_sq_even) else $error("square count odd");

    property p_os_done_high;
        @(posedge i_clock) disable iff (i_rst)
        (mode_r == TCIT_MODE_ONESHOT && st_r == TCIT_ST_DONE) |-> o_out;
    endproperty
    a_os_done_high: assert property (p_os_done_high) else $error("one-shot stuck low");
endmodule // tcit_counter
`default_nettype wire

// ### hw/tcit_pkg.sv
// package: constants and types for the three-channel interval timer
package tcit_pkg;
    localparam int TCIT_NUM_CH = 3;
    localparam int TCIT_CNT_W = 16;
    localparam int TCIT_MODE_W = 3;
    // mode field position within the control byte
    localparam int TCIT_MODE_MSB = 3;
    localparam int TCIT_MODE_LSB = 1;
    // smallest and largest legal counts
    localparam logic [15:0] TCIT_MIN_COUNT = 16'h0002;
    localparam logic [15:0] TCIT_MAX_COUNT = 16'hffff;
    // reset values
    localparam logic [15:0] TCIT_RST_COUNT = 16'h0000;
    localparam logic [2:0] TCIT_RST_MODE = 3'h0;
    // on-board reference clock for counter one
    localparam int TCIT_CLK_HZ = 20000000;
    localparam int TCIT_REF_HZ = 1000000;
    localparam int TCIT_REF_HALF_CYC = TCIT_CLK_HZ / (2 * TCIT_REF_HZ);
    localparam int TCIT_REF_DIV_W = 8;

    typedef enum logic [1:0] {
        TCIT_MODE_TC = 2'h0,
        TCIT_MODE_ONESHOT = 2'h1,
        TCIT_MODE_RATE = 2'h2,
        TCIT_MODE_SQUARE = 2'h3
    } tcit_mode_t;

    // host load request for one counter
    typedef struct packed {
        logic load;
        logic [TCIT_MODE_W-1:0] mode_select_field;
        logic [TCIT_CNT_W-1:0] count;
    } tcit_load_t;

    // per-counter external pins
    typedef struct packed {
        logic clk_in;
        logic gate;
    } tcit_pins_t;

    function automatic tcit_mode_t tcit_decode_mode(input logic [2:0] f);
        tcit_decode_mode = tcit_mode_t'(f[1:0]);
    endfunction
endpackage

// ### hw/tcit_refclk.sv
// module: on-board reference square wave divider
`timescale 1ns/1ps
`default_nettype none
module tcit_refclk
    import tcit_pkg::*;
#(
    parameter int HALF_CYC = TCIT_REF_HALF_CYC
)(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    // square wave
    output logic o_ref
);
    logic [TCIT_REF_DIV_W-1:0] div_r;
    logic [TCIT_REF_DIV_W-1:0] div_nxt;
    logic ref_r;
    logic ref_nxt;
    localparam logic [TCIT_REF_DIV_W-1:0] LAST = TCIT_REF_DIV_W'(HALF_CYC - 1);

    always_comb
    begin
        div_nxt = div_r;
        ref_nxt = ref_r;
        if (div_r == LAST)
        begin
            div_nxt = '0;
            ref_nxt = ~ref_r;
        end
        else
        begin
            div_nxt = div_r + 1'b1;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            div_r <= '0;
            ref_r <= 1'b0;
        end
        else if (i_ce)
        begin
            div_r <= div_nxt;
            ref_r <= ref_nxt;
        end
    end

    assign o_ref = ref_r;
endmodule // tcit_refclk
`default_nettype wire

// ### hw/tcit_top.sv
// module: three-channel interval timer top
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module tcit_top
    import tcit_pkg::*;
#(
    parameter int NUM_CH = TCIT_NUM_CH,
    parameter int CNT_W = TCIT_CNT_W
)(
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    // host loads, one per counter
    input wire tcit_load_t [NUM_CH-1:0] i_load,
    // external clock and gate pins; counter one clock pin unused
    input wire tcit_pins_t [NUM_CH-1:0] i_pins,
    // counter outputs and counts
    output logic [NUM_CH-1:0] o_out,
    output logic [NUM_CH-1:0][CNT_W-1:0] o_count,
    // reference clock output
    output logic o_ref_clk
);
    logic ref_clk;
    tcit_pins_t [NUM_CH-1:0] pins;

    // ------------------------------------------------------------------
    // reference clock
    // ------------------------------------------------------------------
    tcit_refclk u_ref (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .o_ref(ref_clk)
    );
    assign o_ref_clk = ref_clk;

    // ------------------------------------------------------------------
    // counters
    // ------------------------------------------------------------------
    always_comb
    begin
        pins = i_pins;
        pins[1].clk_in = ref_clk;
    end

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        tcit_counter #(.CNT_W(CNT_W)) u_cnt (
            .i_clock(i_clock),
            .i_rst(i_rst),
            .i_ce(i_ce),
            .i_load(i_load[g]),
            .i_pins(pins[g]),
            .o_out(o_out[g]),
            .o_count(o_count[g])
        );
    end
endmodule // tcit_top
`default_nettype wire

// ### tb/tcit_pin_model.sv
// partner model: external clock and gate pins of the three counters
`timescale 1ns/1ps
`default_nettype none
module tcit_pin_model
    import tcit_pkg::*;
(
    // clock
    input wire logic i_clock,
    // pin controls from the bench
    input wire logic [2:0] i_run,
    input wire logic [2:0] i_gate,
    // pins
    output var tcit_pins_t [2:0] o_pins
);
    // ------------------------------------------------------------
    // clock pins: four system cycles per period
    // ------------------------------------------------------------
    logic [1:0] ph_r = 2'h0;

    always @(negedge i_clock)
    begin
        ph_r <= ph_r + 2'h1;
    end

    always_comb
    begin
        for (int c = 0; c < 3; c++)
        begin
            // stopped clock pin sits high on its pull-up
            o_pins[c].clk_in = i_run[c] ? ph_r[1] : 1'b1;
            o_pins[c].gate = i_gate[c];
        end
    end
endmodule // tcit_pin_model
`default_nettype wire

// ### tb/three_channel_interval_timer_tb_top.sv
// testbench: directed scenarios for the three-channel interval timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
        begin \
            bad_count++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
        end \
    end
module three_channel_interval_timer_tb_top
    import tcit_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    tcit_load_t [2:0] ld = '0;
    logic [2:0] run = 3'h0;
    logic [2:0] gate = 3'h7;
    tcit_pins_t [2:0] pins;
    logic [2:0] out;
    logic [2:0][15:0] cnt;
    logic ref_clk;
    int rises[3] = '{0, 0, 0};
    logic [2:0] prv = 3'h7;
    int bad_count = 0;
    int samples_checked = 0;

    tcit_top dut_u (
        .i_clock(clk), .i_rst(rst), .i_ce(ce), .i_load(ld), .i_pins(pins),
        .o_out(out), .o_count(cnt), .o_ref_clk(ref_clk)
    );
    tcit_pin_model pin_u (.i_clock(clk), .i_run(run), .i_gate(gate), .o_pins(pins));

    initial
    begin
        forever #25 clk = ~clk;
    end

    // counts clock pin rises per counter
    always @(posedge clk)
    begin
        for (int c = 0; c < 3; c++)
        begin
            if (pins[c].clk_in && !prv[c])
                rises[c]++;
        end
        prv <= {pins[2].clk_in, pins[1].clk_in, pins[0].clk_in};
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic load(input int c, input logic [2:0] m, input logic [15:0] n);
        @(negedge clk);
        ld[c] = {1'b1, m, n};
        @(negedge clk);
        ld[c].load = 1'b0;
    endtask

    task automatic trig(input int c);
        gate[c] = 1'b0;
        @(negedge clk);
        gate[c] = 1'b1;
        @(negedge clk);
    endtask

    task automatic wait_out(input int c, input logic v, output int r);
        int n;
        n = 0;
        while (out[c] !== v && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("output level", v, out[c])
        r = rises[c];
    endtask

    task automatic wait_rise(input int c, input int k);
        int s;
        s = rises[c];
        while (rises[c] < s + k)
            @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_mode0();
        int a;
        logic [15:0] h;
        gate[0] = 1'b0;
        run[0] = 1'b1;
        load(0, 3'h0, 16'h0003);
        @(negedge clk);
        `CHK("m0 low after load", 1'b0, out[0])
        wait_rise(0, 3);
        `CHK("m0 idle before trigger", 16'h0003, cnt[0])
        gate[0] = 1'b1;
        wait_rise(0, 1);
        @(negedge clk);
        gate[0] = 1'b0;
        h = cnt[0];
        `CHK("m0 first step", 16'h0002, h)
        wait_rise(0, 3);
        `CHK("m0 held by gate", h, cnt[0])
        `CHK("m0 still low", 1'b0, out[0])
        gate[0] = 1'b1;
        wait_out(0, 1'b1, a);
        wait_rise(0, 3);
        `CHK("m0 stays high", 1'b1, out[0])
    endtask

    task automatic t_mode1();
        int a, b;
        load(0, 3'h1, 16'h0004);
        trig(0);
        wait_out(0, 1'b0, a);
        wait_out(0, 1'b1, b);
        `CHK("m1 pulse length", 4, b - a)
        trig(0);
        wait_out(0, 1'b0, a);
        wait_rise(0, 2);
        trig(0);
        wait_out(0, 1'b1, b);
        `CHK("m1 extended length", 7, b - a)
    endtask

    task automatic t_mode2();
        int a, b;
        load(0, 3'h6, 16'h0005);
        trig(0);
        wait_out(0, 1'b0, a);
        wait_out(0, 1'b1, b);
        `CHK("m2 low one period", 1, b - a)
        load(0, 3'h6, 16'h0003);
        wait_out(0, 1'b0, b);
        `CHK("m2 period kept", 5, b - a)
        wait_out(0, 1'b1, a);
        wait_out(0, 1'b0, a);
        `CHK("m2 new period", 3, a - b)
        gate[0] = 1'b0;
        wait_rise(0, 8);
        `CHK("m2 stopped high", 1'b1, out[0])
        run[0] = 1'b0;
    endtask

    task automatic t_mode3();
        int a, b, c;
        logic [15:0] h;
        run[2] = 1'b1;
        load(2, 3'h3, 16'h0005);
        trig(2);
        wait_out(2, 1'b0, a);
        wait_out(2, 1'b1, b);
        wait_out(2, 1'b0, c);
        h = cnt[2];
        `CHK("m3 odd low", 2, b - a)
        `CHK("m3 odd high", 3, c - b)
        wait_rise(2, 1);
        @(negedge clk);
        `CHK("m3 step of two", h - 16'h0002, cnt[2])
        load(2, 3'h3, 16'h0002);
        wait_out(2, 1'b1, a);
        wait_out(2, 1'b0, a);
        wait_out(2, 1'b1, b);
        wait_out(2, 1'b0, c);
        `CHK("m3 even high", 1, c - b)
        `CHK("m3 even low", 1, b - a)
        `CHK("other counter untouched", 1'b1, out[0])
    endtask

    task automatic t_ce();
        logic [2:0][15:0] h;
        logic [2:0] o;
        logic r;
        ce = 1'b0;
        @(negedge clk);
        h = cnt;
        o = out;
        r = ref_clk;
        repeat (25) @(negedge clk);
        `CHK("ce holds counts", h, cnt)
        `CHK("ce holds outputs", o, out)
        `CHK("ce holds ref", r, ref_clk)
        ce = 1'b1;
    endtask

    task automatic t_ref();
        int n, m;
        n = 0;
        m = 0;
        while (ref_clk !== 1'b0)
            @(negedge clk);
        while (ref_clk !== 1'b1)
            @(negedge clk);
        while (ref_clk === 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        while (ref_clk === 1'b0 && m < 100)
        begin
            @(negedge clk);
            m++;
        end
        `CHK("ref high span", TCIT_REF_HALF_CYC, n)
        `CHK("ref low span", TCIT_REF_HALF_CYC, m)
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(negedge clk);
        `CHK("outputs in reset", 3'h7, out)
        `CHK("counts in reset", 48'h0, cnt)
        `CHK("ref in reset", 1'b0, ref_clk)
        rst = 1'b0;
        t_mode0();
        t_mode1();
        t_mode2();
        t_mode3();
        t_ce();
        t_ref();
        final_report();
    end

    initial
    begin
        #(50 * 20000);
        bad_count++;
        final_report();
    end
endmodule // three_channel_interval_timer_tb_top
`default_nettype wire
